/* rtl/synth_cfg_regs.sv */
// paged configuration register bank behind a serial slave port
`timescale 1ns/1ps

// What this block does and what its host must do
// RULE1: bit 0 picks crystal or external reference
// RULE2: bit 0 picks 1.8 V or 3.3 V
// RULE3: host sets 3.3 V option if needed
// RULE4: input enable bits power input buffers
// RULE5: input format bits pick pulsed CMOS
// RULE6: input n uses bits n and n+4
// RULE7: 12-bit hysteresis split over two registers
// RULE8: route bits send dividers to output muxes
// RULE9: mode bits make dividers integer-only
// RULE10: host soft resets after integer mode change
// RULE11: host keeps integer bit zero if switching
// RULE12: cleared power bit powers divider down
// RULE13: bits 3:0 gate input fractional divider clocks
// RULE14: bit 5 gates feedback fractional divider clock
// RULE15: host keeps signal loss gates zero
// RULE16: two scratch registers hold written values
// RULE17: offset 0x01 on every page is page
// RULE18: undefined bits read zero, fields read back
// RULE19: high frequency flag bit 3 drives divider
module synth_cfg_regs
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   output synth_cfg_pkg::cfg_s cfg,
   output logic soft_reset
);

   logic sclk_meta, sclk_sync, sclk_prev;
   logic cs_n_meta, cs_n_sync;
   logic sdi_meta, sdi_sync;
   synth_cfg_pkg::frame_state_e state;
   logic [2:0] bit_cnt;
   logic [7:0] rx_sr;
   logic [7:0] tx_sr;
   logic [7:0] cmd;
   logic [7:0] offset;
   logic [7:0] page;
   logic sclk_rise, sclk_fall, byte_done, wr_en, rd_load;
   logic [7:0] rx_byte;
   logic [15:0] reg_addr, rd_addr;

   function automatic logic [7:0] read_reg(input logic [15:0] a, input synth_cfg_pkg::cfg_s c,
                                           input logic [7:0] pg);
      logic [7:0] r;
      r = 8'h00;
      if (a[7:0] == synth_cfg_pkg::OFF_PAGE)
         r = pg; // [RULE17]
      else
      begin
         // unlisted bits stay zero [RULE18]
         case (a)
            synth_cfg_pkg::ADDR_REF_OSC: r[0] = c.ref_external_clock_select;
            synth_cfg_pkg::ADDR_IO_THRESHOLD: r[0] = c.io_threshold_select;
            synth_cfg_pkg::ADDR_INPUT_CTRL: r = {c.input_pulsed_cmos, c.input_enable};
            synth_cfg_pkg::ADDR_INPUT_TO_PD: r[3:0] = c.input_to_phase_detector_enable;
            synth_cfg_pkg::ADDR_HYS_LOW: r = c.input_hysteresis_select[7:0];
            synth_cfg_pkg::ADDR_HYS_HIGH: r[3:0] = c.input_hysteresis_select[11:8];
            synth_cfg_pkg::ADDR_FB_INTEGER: r[0] = c.feedback_integer_mode;
            synth_cfg_pkg::ADDR_HALF_ADD: r[4:0] = c.divider_half_add;
            synth_cfg_pkg::ADDR_ROUTE_EN: r[4:0] = c.divider_route_enable;
            synth_cfg_pkg::ADDR_INT_MODE: r[4:0] = c.divider_integer_mode;
            synth_cfg_pkg::ADDR_POWER_ON: r[4:0] = c.divider_power_on;
            synth_cfg_pkg::ADDR_SCRATCH_A: r = c.dynamic_change_scratch_a;
            synth_cfg_pkg::ADDR_SCRATCH_B: r = c.dynamic_change_scratch_b;
            synth_cfg_pkg::ADDR_FRAC_GATE:
            begin
               r[3:0] = c.input_frac_divider_clock_off;
               r[synth_cfg_pkg::FB_GATE_BIT] = c.feedback_frac_divider_clock_off;
            end
            synth_cfg_pkg::ADDR_LOS_GATE: r[3:0] = c.signal_loss_detector_clock_off;
            default: r = 8'h00;
         endcase
         for (int i = 0; i < synth_cfg_pkg::NUM_HF_DIVIDERS; i++)
         begin
            if (a == synth_cfg_pkg::ADDR_HF[i])
               r[synth_cfg_pkg::HF_BIT] = c.divider_high_frequency[i];
         end
      end
      return r;
   endfunction

   // pins come from the host domain; the first stage feeds only the second
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_meta <= 1'b0;
         sclk_sync <= 1'b0;
         sclk_prev <= 1'b0;
         cs_n_meta <= 1'b1;
         cs_n_sync <= 1'b1;
         sdi_meta <= 1'b0;
         sdi_sync <= 1'b0;
      end
      else
      begin
         sclk_meta <= sclk;
         sclk_sync <= sclk_meta;
         sclk_prev <= sclk_sync;
         cs_n_meta <= cs_n;
         cs_n_sync <= cs_n_meta;
         sdi_meta <= sdi;
         sdi_sync <= sdi_meta;
      end
   end

   // sdi and sclk share the same synchroniser depth, so data lines up with the edge
   assign sclk_rise = sclk_sync && !sclk_prev && !cs_n_sync;
   assign sclk_fall = !sclk_sync && sclk_prev && !cs_n_sync;
   assign byte_done = sclk_rise && (bit_cnt == 3'h7);
   assign rx_byte = {rx_sr[6:0], sdi_sync};
   assign reg_addr = {page, offset};
   assign wr_en = byte_done && (state == synth_cfg_pkg::st_data) && (cmd == synth_cfg_pkg::CMD_WRITE);
   assign rd_load = byte_done && (((state == synth_cfg_pkg::st_cmd) && (rx_byte == synth_cfg_pkg::CMD_READ)) ||
                                  ((state == synth_cfg_pkg::st_data) && (cmd == synth_cfg_pkg::CMD_READ)));
   assign rd_addr = (state == synth_cfg_pkg::st_cmd) ? reg_addr : {page, 8'(offset + 8'h01)};
   assign sdo = tx_sr[7];

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         state <= synth_cfg_pkg::st_idle;
      else if (cs_n_sync)
         state <= synth_cfg_pkg::st_idle;
      else
      begin
         unique case (state)
            synth_cfg_pkg::st_idle: state <= synth_cfg_pkg::st_cmd;
            synth_cfg_pkg::st_cmd:
            begin
               if (byte_done)
                  state <= synth_cfg_pkg::st_data;
            end
            synth_cfg_pkg::st_data: state <= synth_cfg_pkg::st_data;
            default: state <= synth_cfg_pkg::st_idle;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bit_cnt <= 3'h0;
         rx_sr <= 8'h00;
      end
      else if (cs_n_sync)
         bit_cnt <= 3'h0;
      else if (sclk_rise)
      begin
         bit_cnt <= 3'(bit_cnt + 3'h1);
         rx_sr <= rx_byte;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         cmd <= synth_cfg_pkg::CMD_SET_ADDR;
      else if (byte_done && (state == synth_cfg_pkg::st_cmd))
         cmd <= rx_byte;
   end

   // offset auto-increments across a burst so blocks can be streamed
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         offset <= 8'h00;
      else if (byte_done && (state == synth_cfg_pkg::st_data))
      begin
         if (cmd == synth_cfg_pkg::CMD_SET_ADDR)
            offset <= rx_byte;
         else if ((cmd == synth_cfg_pkg::CMD_WRITE) || (cmd == synth_cfg_pkg::CMD_READ))
            offset <= 8'(offset + 8'h01);
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         page <= synth_cfg_pkg::PAGE_RESET;
      else if (wr_en && (offset == synth_cfg_pkg::OFF_PAGE))
         page <= rx_byte; // [RULE17]
   end

   // soft reset is a one-cycle strobe and reads back as zero
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         soft_reset <= 1'b0;
      else
         soft_reset <= wr_en && (reg_addr == synth_cfg_pkg::ADDR_SOFT_RESET) &&
                       rx_byte[synth_cfg_pkg::SOFT_RESET_BIT];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         cfg <= synth_cfg_pkg::CFG_RESET;
      else if (wr_en)
      begin
         case (reg_addr)
            synth_cfg_pkg::ADDR_REF_OSC: cfg.ref_external_clock_select <= rx_byte[0]; // [RULE1]
            synth_cfg_pkg::ADDR_IO_THRESHOLD: cfg.io_threshold_select <= rx_byte[0]; // [RULE2]
            synth_cfg_pkg::ADDR_INPUT_CTRL:
            begin
               cfg.input_enable <= rx_byte[synth_cfg_pkg::INPUT_FMT_LSB-1:0]; // [RULE4] [RULE6]
               cfg.input_pulsed_cmos <= rx_byte[7:synth_cfg_pkg::INPUT_FMT_LSB]; // [RULE5] [RULE6]
            end
            synth_cfg_pkg::ADDR_INPUT_TO_PD: cfg.input_to_phase_detector_enable <= rx_byte[3:0];
            synth_cfg_pkg::ADDR_HYS_LOW: cfg.input_hysteresis_select[7:0] <= rx_byte; // [RULE7]
            synth_cfg_pkg::ADDR_HYS_HIGH: cfg.input_hysteresis_select[11:8] <= rx_byte[3:0]; // [RULE7]
            synth_cfg_pkg::ADDR_FB_INTEGER: cfg.feedback_integer_mode <= rx_byte[0];
            synth_cfg_pkg::ADDR_HALF_ADD: cfg.divider_half_add <= rx_byte[4:0];
            synth_cfg_pkg::ADDR_ROUTE_EN: cfg.divider_route_enable <= rx_byte[4:0]; // [RULE8]
            synth_cfg_pkg::ADDR_INT_MODE: cfg.divider_integer_mode <= rx_byte[4:0]; // [RULE9]
            synth_cfg_pkg::ADDR_POWER_ON: cfg.divider_power_on <= rx_byte[4:0]; // [RULE12]
            synth_cfg_pkg::ADDR_SCRATCH_A: cfg.dynamic_change_scratch_a <= rx_byte; // [RULE16]
            synth_cfg_pkg::ADDR_SCRATCH_B: cfg.dynamic_change_scratch_b <= rx_byte; // [RULE16]
            synth_cfg_pkg::ADDR_FRAC_GATE:
            begin
               cfg.input_frac_divider_clock_off <= rx_byte[3:0]; // [RULE13]
               cfg.feedback_frac_divider_clock_off <= rx_byte[synth_cfg_pkg::FB_GATE_BIT]; // [RULE14]
            end
            synth_cfg_pkg::ADDR_LOS_GATE: cfg.signal_loss_detector_clock_off <= rx_byte[3:0];
            default: ;
         endcase
         for (int i = 0; i < synth_cfg_pkg::NUM_HF_DIVIDERS; i++)
         begin
            if (reg_addr == synth_cfg_pkg::ADDR_HF[i])
               cfg.divider_high_frequency[i] <= rx_byte[synth_cfg_pkg::HF_BIT]; // [RULE19]
         end
      end
   end

   // the first falling edge of a byte presents bit 7 without shifting it away
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         tx_sr <= 8'h00;
      else if (cs_n_sync)
         tx_sr <= 8'h00;
      else if (rd_load)
         tx_sr <= read_reg(rd_addr, cfg, page); // [RULE18]
      else if (sclk_fall && (bit_cnt != 3'h0))
         tx_sr <= {tx_sr[6:0], 1'b0};
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         sdo_oe <= 1'b0;
      else
         sdo_oe <= !cs_n_sync && (state == synth_cfg_pkg::st_data) && (cmd == synth_cfg_pkg::CMD_READ);
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   ref_src_write_a: assert property (wr_en && reg_addr == synth_cfg_pkg::ADDR_REF_OSC |=> // [RULE1]
      cfg.ref_external_clock_select == $past(rx_byte[0])) else $error("reference select not stored");
   io_sel_write_a: assert property (wr_en && reg_addr == synth_cfg_pkg::ADDR_IO_THRESHOLD |=> // [RULE2]
      cfg.io_threshold_select == $past(rx_byte[0])) else $error("threshold select not stored");
   input_ctrl_map_a: assert property (wr_en && reg_addr == synth_cfg_pkg::ADDR_INPUT_CTRL |=> // [RULE6]
      {cfg.input_pulsed_cmos, cfg.input_enable} == $past(rx_byte)) else $error("input control bits misplaced");
   hys_split_a: assert property (wr_en && reg_addr == synth_cfg_pkg::ADDR_HYS_HIGH |=> // [RULE7]
      cfg.input_hysteresis_select[11:8] == $past(rx_byte[3:0]) && $stable(cfg.input_hysteresis_select[7:0]))
      else $error("hysteresis high part wrong");
   divider_ctrl_a: assert property (wr_en && reg_addr == synth_cfg_pkg::ADDR_POWER_ON |=> // [RULE12]
      cfg.divider_power_on == $past(rx_byte[4:0]) && $stable(cfg.divider_integer_mode))
      else $error("divider power bits wrong");
   frac_gate_a: assert property (wr_en && reg_addr == synth_cfg_pkg::ADDR_FRAC_GATE |=> // [RULE14]
      cfg.feedback_frac_divider_clock_off == $past(rx_byte[5]) &&
      cfg.input_frac_divider_clock_off == $past(rx_byte[3:0])) else $error("clock gate bits wrong");
   cfg_hold_a: assert property (!wr_en |=> $stable(cfg)) else $error("config changed without write"); // [RULE16]
   page_switch_a: assert property (wr_en && offset == 8'h01 |=> page == $past(rx_byte)) // [RULE17]
      else $error("page not switched");
   unused_zero_a: assert property (rd_load && rd_addr == synth_cfg_pkg::ADDR_ROUTE_EN |=> // [RULE18]
      tx_sr[7:5] == 3'h0 && tx_sr[4:0] == cfg.divider_route_enable) else $error("route readback wrong");
   high_freq_a: assert property (wr_en && reg_addr == synth_cfg_pkg::ADDR_HF[2] |=> // [RULE19]
      cfg.divider_high_frequency[2] == $past(rx_byte[3])) else $error("high frequency flag wrong");
   route_write_a: assert property (wr_en && reg_addr == synth_cfg_pkg::ADDR_ROUTE_EN |=> // [RULE8]
      cfg.divider_route_enable == $past(rx_byte[4:0])) else $error("route bits not stored");
   int_mode_write_a: assert property (wr_en && reg_addr == synth_cfg_pkg::ADDR_INT_MODE |=> // [RULE9]
      cfg.divider_integer_mode == $past(rx_byte[4:0])) else $error("integer mode bits not stored");
   scratch_write_a: assert property (wr_en && reg_addr == synth_cfg_pkg::ADDR_SCRATCH_A |=> // [RULE16]
      cfg.dynamic_change_scratch_a == $past(rx_byte) && $stable(cfg.dynamic_change_scratch_b))
      else $error("scratch register not stored");

   page_read_c: cover property (rd_load && rd_addr[7:0] == synth_cfg_pkg::OFF_PAGE);
   burst_write_c: cover property (wr_en ##[1:200] wr_en);
   soft_reset_c: cover property (soft_reset);
   scratch_write_c: cover property (wr_en && reg_addr == synth_cfg_pkg::ADDR_SCRATCH_B);

endmodule

/* rtl/synth_cfg_pkg.sv */
// constants, field layout and types of the synthesizer configuration bank
package synth_cfg_pkg;
   localparam int NUM_INPUTS = 4;
   localparam int NUM_DIVIDERS = 5;
   localparam int NUM_HF_DIVIDERS = 4;
   localparam int HYS_WIDTH = 12;
   localparam int HYS_LOW_WIDTH = 8;

   // register addresses, {page, offset}
   localparam logic [7:0] OFF_PAGE = 8'h01;
   localparam logic [15:0] ADDR_SOFT_RESET = 16'h001c;
   localparam logic [15:0] ADDR_REF_OSC = 16'h090e;
   localparam logic [15:0] ADDR_IO_THRESHOLD = 16'h0943;
   localparam logic [15:0] ADDR_INPUT_CTRL = 16'h0949;
   localparam logic [15:0] ADDR_INPUT_TO_PD = 16'h094a;
   localparam logic [15:0] ADDR_HYS_LOW = 16'h094e;
   localparam logic [15:0] ADDR_HYS_HIGH = 16'h094f;
   localparam logic [15:0] ADDR_FB_INTEGER = 16'h095e;
   localparam logic [15:0] ADDR_HALF_ADD = 16'h0a02;
   localparam logic [15:0] ADDR_ROUTE_EN = 16'h0a03;
   localparam logic [15:0] ADDR_INT_MODE = 16'h0a04;
   localparam logic [15:0] ADDR_POWER_ON = 16'h0a05;
   localparam logic [15:0] ADDR_HF [NUM_HF_DIVIDERS] = '{16'h0a14, 16'h0a1a, 16'h0a20, 16'h0a26};
   localparam logic [15:0] ADDR_SCRATCH_A = 16'h0b24;
   localparam logic [15:0] ADDR_SCRATCH_B = 16'h0b25;
   localparam logic [15:0] ADDR_FRAC_GATE = 16'h0b44;
   localparam logic [15:0] ADDR_LOS_GATE = 16'h0b46;

   // field positions
   localparam int INPUT_FMT_LSB = 4;
   localparam int HF_BIT = 3;
   localparam int FB_GATE_BIT = 5;
   localparam int SOFT_RESET_BIT = 0;

   // serial command bytes
   localparam logic [7:0] CMD_SET_ADDR = 8'h00;
   localparam logic [7:0] CMD_WRITE = 8'h40;
   localparam logic [7:0] CMD_READ = 8'h80;

   localparam logic [7:0] PAGE_RESET = 8'h00;

   typedef struct packed {
      logic ref_external_clock_select;
      logic io_threshold_select;
      logic [NUM_INPUTS-1:0] input_enable;
      logic [NUM_INPUTS-1:0] input_pulsed_cmos;
      logic [NUM_INPUTS-1:0] input_to_phase_detector_enable;
      logic [HYS_WIDTH-1:0] input_hysteresis_select;
      logic feedback_integer_mode;
      logic [NUM_DIVIDERS-1:0] divider_half_add;
      logic [NUM_DIVIDERS-1:0] divider_route_enable;
      logic [NUM_DIVIDERS-1:0] divider_integer_mode;
      logic [NUM_DIVIDERS-1:0] divider_power_on;
      logic [NUM_HF_DIVIDERS-1:0] divider_high_frequency;
      logic [7:0] dynamic_change_scratch_a;
      logic [7:0] dynamic_change_scratch_b;
      logic [NUM_INPUTS-1:0] input_frac_divider_clock_off;
      logic feedback_frac_divider_clock_off;
      logic [NUM_INPUTS-1:0] signal_loss_detector_clock_off;
   } cfg_s;

   localparam cfg_s CFG_RESET = '0;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_cmd = 2'b01,
      st_data = 2'b11
   } frame_state_e;
endpackage

/* bench/spi_host_model.sv */
// host side of the serial configuration port: mode 0, most significant bit first
`timescale 1ns/1ps
module spi_host_model
(
   input wire logic mclk,
   input wire logic sdo,
   input wire logic sdo_oe,
   output logic sclk,
   output logic cs_n,
   output logic sdi
);
   // mclk cycles per sclk phase, one more than the minimum the port accepts
   localparam int HALF = 5;

   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end

   // unselected data line keeps toggling so a stale bit never reads as valid
   always @(posedge mclk)
      if (cs_n)
         sdi <= ~sdi;

   // one frame of two or three bytes, tx left aligned and nbits long; rx collects what came back
   // after the command byte, unknown wherever the device was not driving sdo
   task automatic shift_frame(input logic [23:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge mclk);
      cs_n <= 1'b0;
      repeat (HALF + 1) @(posedge mclk);
      for (int i = 23; i >= 24 - nbits; i--)
      begin
         sdi <= tx[i];
         repeat (HALF) @(posedge mclk);
         sclk <= 1'b1;
         if (i < 16)
            rx = {rx[14:0], (sdo_oe === 1'b1) ? sdo : 1'bx};
         repeat (HALF) @(posedge mclk);
         sclk <= 1'b0;
      end
      repeat (HALF) @(posedge mclk);
      cs_n <= 1'b1;
      repeat (HALF + 1) @(posedge mclk);
   endtask

   // one frame of two bytes; rx is what came back in the second byte
   task automatic frame(input logic [7:0] b0, input logic [7:0] b1, output logic [7:0] rx);
      logic [15:0] r;
      shift_frame({b0, b1, 8'h00}, 16, r);
      rx = r[7:0];
   endtask
endmodule

/* bench/clock_synth_config_registers_tb_top.sv */
// self-checking bench: random register traffic against a table model of the bank
`timescale 1ns/1ps
module clock_synth_config_registers_tb_top;
   localparam int N_ADDR = 22;
   localparam logic [15:0] ADDRS [N_ADDR] = '{16'h090e, 16'h0943, 16'h0949, 16'h094a, 16'h094e, 16'h094f,
      16'h095e, 16'h0a02, 16'h0a03, 16'h0a04, 16'h0a05, 16'h0a14, 16'h0a1a, 16'h0a20, 16'h0a26, 16'h0b24,
      16'h0b25, 16'h0b44, 16'h0b46, 16'h0a13, 16'h0b45, 16'h001c};
   localparam logic [7:0] MASKS [N_ADDR] = '{8'h01, 8'h01, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h01, 8'h1f, 8'h1f,
      8'h1f, 8'h1f, 8'h08, 8'h08, 8'h08, 8'h08, 8'hff, 8'hff, 8'h2f, 8'h0f, 8'h00, 8'h00, 8'h00};
   logic mclk;
   logic rst_n;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   logic soft_reset;
   synth_cfg_pkg::cfg_s cfg;
   logic [7:0] mem [65536];
   logic [7:0] cur_page;
   logic [7:0] q;
   logic [7:0] d;
   logic [15:0] w;
   int miscompares = 0;
   int checks_done = 0;
   int sr_seen = 0;
   int sr_exp = 0;
   int cycles = 0;

   synth_cfg_regs DUT (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
      .sdo_oe(sdo_oe), .cfg(cfg), .soft_reset(soft_reset));
   spi_host_model host (.mclk(mclk), .sdo(sdo), .sdo_oe(sdo_oe), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      cycles++;
      if (soft_reset === 1'b1)
         sr_seen++;
      if (cycles == 80000)
      begin
         miscompares++;
         $display("ERROR timeout expected completion seen hang");
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_cfg(input synth_cfg_pkg::cfg_s exp);
      checks_done++;
      if (cfg !== exp)
      begin
         miscompares++;
         $display("ERROR cfg expected %h seen %h", exp, cfg);
      end
   endtask

   function automatic synth_cfg_pkg::cfg_s exp_cfg();
      synth_cfg_pkg::cfg_s c;
      c = '0;
      c.ref_external_clock_select = mem[16'h090e][0];
      c.io_threshold_select = mem[16'h0943][0];
      c.input_enable = mem[16'h0949][3:0];
      c.input_pulsed_cmos = mem[16'h0949][7:4];
      c.input_to_phase_detector_enable = mem[16'h094a][3:0];
      c.input_hysteresis_select = {mem[16'h094f][3:0], mem[16'h094e]};
      c.feedback_integer_mode = mem[16'h095e][0];
      c.divider_half_add = mem[16'h0a02][4:0];
      c.divider_route_enable = mem[16'h0a03][4:0];
      c.divider_integer_mode = mem[16'h0a04][4:0];
      c.divider_power_on = mem[16'h0a05][4:0];
      for (int n = 0; n < synth_cfg_pkg::NUM_HF_DIVIDERS; n++)
         c.divider_high_frequency[n] = mem[synth_cfg_pkg::ADDR_HF[n]][3];
      c.dynamic_change_scratch_a = mem[16'h0b24];
      c.dynamic_change_scratch_b = mem[16'h0b25];
      c.input_frac_divider_clock_off = mem[16'h0b44][3:0];
      c.feedback_frac_divider_clock_off = mem[16'h0b44][5];
      c.signal_loss_detector_clock_off = mem[16'h0b46][3:0];
      return c;
   endfunction

   // page switches cost two frames, so they are skipped while the page already matches
   task automatic select(input logic [15:0] a);
      logic [7:0] rx;
      if (a[15:8] !== cur_page)
      begin
         host.frame(8'h00, 8'h01, rx);
         host.frame(8'h40, a[15:8], rx);
         cur_page = a[15:8];
      end
      host.frame(8'h00, a[7:0], rx);
   endtask

   task automatic reg_write(input int i, input logic [7:0] v);
      logic [7:0] rx;
      select(ADDRS[i]);
      host.frame(8'h40, v, rx);
      mem[ADDRS[i]] = v & MASKS[i];
      if (ADDRS[i] == 16'h001c && v[0])
         sr_exp++;
   endtask

   task automatic reg_read(input logic [15:0] a, output logic [7:0] v);
      select(a);
      host.frame(8'h80, 8'h00, v);
   endtask

   task automatic clear_model();
      foreach (mem[k])
         mem[k] = 8'h00;
      cur_page = 8'h00;
   endtask

   initial
   begin
      rst_n = 1'b0;
      clear_model();
      void'($urandom(32'hb289));
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      reg_write(1, 8'h01);
      for (int r = 0; r < 2; r++)
      begin
         for (int i = 0; i < N_ADDR; i++)
         begin
            d = 8'($urandom);
            if (r == 1 && (ADDRS[i] == 16'h0a04 || ADDRS[i] == 16'h0b46))
               d = 8'h00;
            if (r == 1 && ADDRS[i] == 16'h0a05)
               d = 8'h1f;
            reg_write(i, d);
            if (ADDRS[i] == 16'h0a04)
               reg_write(N_ADDR - 1, 8'h01);
            check_cfg(exp_cfg());
         end
         for (int i = 0; i < N_ADDR; i++)
         begin
            reg_read(ADDRS[i], q);
            check_byte("readback", mem[ADDRS[i]], q);
         end
         check_byte("soft reset pulses", 8'(sr_exp), 8'(sr_seen));
         $display("test random round %0d done", r);
      end
      reg_read(16'h0a01, q);
      check_byte("page", 8'h0a, q);
      reg_read(16'h0b01, q);
      check_byte("page", 8'h0b, q);
      $display("test page register done");
      d = 8'($urandom);
      q = 8'($urandom);
      select(16'h0b24);
      host.shift_frame({8'h40, d, q}, 24, w);
      mem[16'h0b24] = d;
      mem[16'h0b25] = q;
      check_cfg(exp_cfg());
      select(16'h0b24);
      host.frame(8'hc0, ~d, q);
      check_cfg(exp_cfg());
      select(16'h0b24);
      host.shift_frame({8'h80, 16'h0000}, 24, w);
      check_byte("burst read first", mem[16'h0b24], w[15:8]);
      check_byte("burst read second", mem[16'h0b25], w[7:0]);
      $display("test burst done");
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      clear_model();
      check_cfg(synth_cfg_pkg::CFG_RESET);
      reg_read(16'h0001, q);
      check_byte("page after reset", 8'h00, q);
      reg_read(16'h0b24, q);
      check_byte("scratch after reset", 8'h00, q);
      $display("test mid-run reset done");
      finish_test();
   end
endmodule
